/* File: logic/fpp_mem.v */
// Code flash array model: 4096 x 8, registered read.
// Assumes one write port and one read port on the core clock.
`timescale 1ns/100ps
`include "fpp_regs.vh"
module fpp_mem (
	// Clock
	input wire clk,
	input wire clk_en,
	// Write port
	input wire wr_en,
	input wire erase,
	input wire [11:0] wr_addr,
	input wire [7:0] wr_data,
	// Read port
	input wire [11:0] rd_addr,
	output reg [7:0] rd_data
);
reg [7:0] mem [0:4095];
integer i;
////////////////////////////////////////////////////////////////
// Erase is a loop over all words; costly in area but a model only
always @(posedge clk) begin
	if (clk_en) begin
		if (erase) begin
			for (i = 0; i < 4096; i = i + 1) begin
				mem[i] <= `FPP_ERASED;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
end
endmodule

/* File: logic/fpp_regs.vh */
// Constants for the flash programming port: timing counts, opcodes, select codes.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef FPP_REGS_VH
`define FPP_REGS_VH
`define FPP_CLK_MHZ 10
// Parallel byte write cycle, at most 50 us
`define FPP_PWRITE_US 50
`define FPP_PWRITE_CYC (`FPP_PWRITE_US * `FPP_CLK_MHZ)
// Serial byte write cycle, at most 0.5 ms (given in us)
`define FPP_SWRITE_US 500
`define FPP_SWRITE_CYC ((`FPP_SWRITE_US * `FPP_CLK_MHZ) - 1)
// Chip erase, cut to the byte write time to keep simulation short
`define FPP_ERASE_CYC `FPP_PWRITE_CYC
// Serial opcodes (first byte), FPP_OP_ENABLE2 second enable byte, FPP_ENABLE_ECHO reply byte
`define FPP_OP_ENABLE 8'hAC
`define FPP_OP_ENABLE2 8'h53
`define FPP_OP_READ 8'h20
`define FPP_OP_WRITE 8'h40
`define FPP_OP_LOCKRD 8'h24
`define FPP_OP_SIGRD 8'h28
`define FPP_ENABLE_ECHO 8'h69
// Parallel selects {a,enable,b,c,d}
`define FPP_SEL_WRITE 5'h0F
`define FPP_SEL_READ 5'h03
`define FPP_SEL_ERASE 5'h14
`define FPP_SEL_LOCK1 5'h1F
`define FPP_SEL_LOCK2 5'h1C
`define FPP_SEL_LOCK3 5'h16
`define FPP_SEL_LOCKRD 5'h1A
`define FPP_SEL_IDENT 5'h00
// Identity bytes, arbitrary neutral values
`define FPP_ID0 8'h5A
`define FPP_ID1 8'hA5
`define FPP_ID2 8'h3C
`define FPP_ERASED 8'hFF
`define FPP_ADDR_W 12
`endif

/* File: logic/fpp_top.v */
// Flash programming port: serial four-byte instructions and parallel select-code mode.
// Assumes all pins are asynchronous to clk; sck is far slower than clk.
`timescale 1ns/100ps
`include "fpp_regs.vh"
module fpp_top (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	input wire clk_en,
	// Programming reset pin (high = programming)
	input wire prog_reset,
	// Serial pins
	input wire sck,
	input wire mosi,
	output reg miso,
	output wire miso_oe,
	// Parallel control pins
	input wire program_store_enable_n,
	input wire program_strobe,
	input wire high_voltage_enable,
	input wire mode_select_a,
	input wire mode_select_enable,
	input wire mode_select_b,
	input wire mode_select_c,
	input wire mode_select_d,
	// Parallel address and data
	input wire [3:0] high_address_port,
	input wire [7:0] low_address_port,
	input wire [7:0] data_port_in,
	output reg [7:0] data_port_out,
	output wire data_port_oe,
	// Busy pin, low while busy
	output wire busy_output_pin,
	// Lock bits and session status
	output reg [2:0] lock_bits_q,
	output wire prog_enabled
);
////////////////////////////////////////////////////////////////
// Two-flop synchronisers for every pin input
localparam NSYNC = 10;
wire [NSYNC-1:0] raw = {prog_reset, sck, mosi, program_store_enable_n, program_strobe,
	high_voltage_enable, mode_select_a, mode_select_enable, mode_select_b, mode_select_c};
reg [NSYNC-1:0] s1_q, s2_q;
reg sd1_q, sd2_q;
reg [19:0] bus1_q, bus2_q;
always @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		s1_q <= 10'h000;
		s2_q <= 10'h000;
		sd1_q <= 1'b0;
		sd2_q <= 1'b0;
		bus1_q <= 20'h0_0000;
		bus2_q <= 20'h0_0000;
	end else if (clk_en) begin
		s1_q <= raw;
		s2_q <= s1_q;
		sd1_q <= mode_select_d;
		sd2_q <= sd1_q;
		bus1_q <= {high_address_port, low_address_port, data_port_in};
		bus2_q <= bus1_q;
	end
end
wire rst_s = s2_q[9];
wire sck_s = s2_q[8];
wire mosi_s = s2_q[7];
wire program_store_enable_n_n_s = s2_q[6];
wire strobe_s = s2_q[5];
wire hv_s = s2_q[4];
wire [4:0] sel = {s2_q[3:0], sd2_q};
wire [11:0] paddr = bus2_q[19:8];
wire [7:0] pdin = bus2_q[7:0];
reg sck_p_q, strobe_p_q;
wire sck_rise = sck_s & ~sck_p_q;
wire sck_fall = ~sck_s & sck_p_q;
wire strobe_rise = strobe_s & ~strobe_p_q;
wire par_mode = rst_s & ~program_store_enable_n_n_s;
////////////////////////////////////////////////////////////////
// State
localparam ST_IDLE = 2'd0;
localparam ST_WRITE = 2'd1;
localparam ST_ERASE = 2'd2;
reg [1:0] st_q;
reg [13:0] cnt_q;
reg [11:0] last_addr_q;
reg [7:0] last_data_q;
reg [4:0] bitc_q;
reg [31:0] sh_q;
reg [7:0] tx_q;
reg en_q;
reg mem_we_q, mem_er_q;
reg [11:0] mem_wa_q;
reg [7:0] mem_wd_q;
wire busy = (st_q != ST_IDLE);
wire [7:0] rd_data;
// Two-entry output buffer for read words into the serial shifter
reg [7:0] fb_q [0:1];
reg [1:0] fb_cnt_q;
reg fb_wp_q, fb_rp_q;
wire fb_in_ready = (fb_cnt_q != 2'd2);
wire fb_out_valid = (fb_cnt_q != 2'd0);
reg fb_push, fb_pop;
reg [7:0] fb_din;
assign prog_enabled = en_q;
// Busy pin, low while cycle runs
assign busy_output_pin = ~busy;
assign miso_oe = rst_s & en_q;
wire mode_select_enable_s = sel[3];
assign data_port_oe = par_mode & hv_s & ~mode_select_enable_s;
// Address is complete once the third byte is in
wire [11:0] sreq_addr = sh_q[11:0];
// Reply request delayed two clocks so the registered read has settled
reg [1:0] rq_q;
// Cycle counter loads, cut to the counter width on purpose
localparam integer PW_LOAD = `FPP_PWRITE_CYC - 1;
localparam integer ER_LOAD = `FPP_ERASE_CYC - 1;
localparam integer SW_LOAD = `FPP_SWRITE_CYC;
////////////////////////////////////////////////////////////////
// Main sequencer
always @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		sck_p_q <= 1'b0;
		strobe_p_q <= 1'b0;
		st_q <= ST_IDLE;
		cnt_q <= 14'h0000;
		last_addr_q <= 12'h000;
		last_data_q <= 8'h00;
		bitc_q <= 5'h00;
		sh_q <= 32'h0000_0000;
		tx_q <= 8'h00;
		en_q <= 1'b0;
		miso <= 1'b0;
		mem_we_q <= 1'b0;
		mem_er_q <= 1'b0;
		mem_wa_q <= 12'h000;
		mem_wd_q <= 8'h00;
		lock_bits_q <= 3'h0;
		fb_cnt_q <= 2'd0;
		fb_wp_q <= 1'b0;
		fb_rp_q <= 1'b0;
		fb_q[0] <= 8'h00;
		fb_q[1] <= 8'h00;
		data_port_out <= 8'h00;
		rq_q <= 2'b00;
	end else if (clk_en) begin
		rq_q <= {rq_q[0], rst_s & sck_rise & (bitc_q == 5'd23)};
		sck_p_q <= sck_s;
		strobe_p_q <= strobe_s;
		mem_we_q <= 1'b0;
		mem_er_q <= 1'b0;
		if (busy) begin
			if (cnt_q == 14'h0000) begin
				st_q <= ST_IDLE;
			end else begin
				cnt_q <= cnt_q - 14'h0001;
			end
		end
		// Strobe only taken when idle; busy next cycle
		if (par_mode && hv_s && strobe_rise && !busy) begin
			if (sel == `FPP_SEL_WRITE) begin
				mem_we_q <= 1'b1;
				mem_wa_q <= paddr;
				mem_wd_q <= pdin;
				last_addr_q <= paddr;
				last_data_q <= pdin;
				st_q <= ST_WRITE;
				cnt_q <= PW_LOAD[13:0];
			end else if (sel == `FPP_SEL_ERASE) begin
				mem_er_q <= 1'b1;
				lock_bits_q <= 3'h0;
				st_q <= ST_ERASE;
				cnt_q <= ER_LOAD[13:0];
			end else if (sel == `FPP_SEL_LOCK1) begin
				lock_bits_q[0] <= 1'b1;
				st_q <= ST_WRITE;
				cnt_q <= PW_LOAD[13:0];
			end else if (sel == `FPP_SEL_LOCK2) begin
				lock_bits_q[1] <= 1'b1;
				st_q <= ST_WRITE;
				cnt_q <= PW_LOAD[13:0];
			end else if (sel == `FPP_SEL_LOCK3) begin
				lock_bits_q[2] <= 1'b1;
				st_q <= ST_WRITE;
				cnt_q <= PW_LOAD[13:0];
			end
		end
		if (sel == `FPP_SEL_READ) begin
			if (busy && paddr == last_addr_q) begin
				data_port_out <= {~last_data_q[7], last_data_q[6:0]};
			end else begin
				data_port_out <= rd_data;
			end
		end else if (sel == `FPP_SEL_LOCKRD) begin
			data_port_out <= {3'h0, lock_bits_q, 2'h0};
		end else if (sel == `FPP_SEL_IDENT) begin
			if (paddr == 12'h000) begin
				data_port_out <= `FPP_ID0;
			end else if (paddr == 12'h100) begin
				data_port_out <= `FPP_ID1;
			end else begin
				data_port_out <= `FPP_ID2;
			end
		end
		if (!rst_s) begin
			en_q <= 1'b0;
			bitc_q <= 5'h00;
		end else if (sck_rise) begin
			sh_q <= {sh_q[30:0], mosi_s};
			bitc_q <= bitc_q + 5'h01;
			if (bitc_q == 5'd31) begin
				// Only the enable instruction until enabled
				if (sh_q[30:23] == `FPP_OP_ENABLE && sh_q[22:15] == `FPP_OP_ENABLE2) begin
					en_q <= 1'b1;
				end else if (en_q && sh_q[30:23] == `FPP_OP_WRITE && !busy) begin
					mem_we_q <= 1'b1;
					mem_wa_q <= sh_q[18:7];
					mem_wd_q <= {sh_q[6:0], mosi_s};
					last_addr_q <= sh_q[18:7];
					last_data_q <= {sh_q[6:0], mosi_s};
					st_q <= ST_WRITE;
					cnt_q <= SW_LOAD[13:0];
				end
			end
		end else if (sck_fall) begin
			miso <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
			// Load reply byte at start of fourth byte
			if (bitc_q == 5'd24 && fb_out_valid) begin
				miso <= fb_q[fb_rp_q][7];
				tx_q <= {fb_q[fb_rp_q][6:0], 1'b0};
			end
		end
		// Buffer bookkeeping
		if (fb_push) begin
			fb_q[fb_wp_q] <= fb_din;
			fb_wp_q <= ~fb_wp_q;
		end
		if (fb_pop) begin
			fb_rp_q <= ~fb_rp_q;
		end
		fb_cnt_q <= fb_cnt_q + {1'b0, fb_push} - {1'b0, fb_pop};
	end
end
////////////////////////////////////////////////////////////////
// Reply selection after the third byte is in; reply dropped when buffer full
reg [11:0] rd_addr;
always @* begin
	fb_push = 1'b0;
	fb_din = 8'h00;
	rd_addr = par_mode ? paddr : sreq_addr;
	fb_pop = sck_fall && bitc_q == 5'd24 && fb_out_valid && rst_s;
	if (rst_s && rq_q[1] && fb_in_ready) begin
		fb_push = 1'b1;
		// Serial read; inverted MSB while writing
		if (sh_q[23:16] == `FPP_OP_ENABLE) begin
			fb_din = `FPP_ENABLE_ECHO;
		end else if (!en_q) begin
			fb_din = 8'h00;
		end else if (sh_q[23:16] == `FPP_OP_READ) begin
			if (busy && sreq_addr == last_addr_q) begin
				fb_din = {~last_data_q[7], last_data_q[6:0]};
			end else begin
				fb_din = rd_data;
			end
		end else if (sh_q[23:16] == `FPP_OP_LOCKRD) begin
			fb_din = {3'h0, lock_bits_q, 2'h0};
		end else if (sh_q[23:16] == `FPP_OP_SIGRD) begin
			fb_din = `FPP_ID0;
		end
	end
end
////////////////////////////////////////////////////////////////
// Flash array
fpp_mem u_mem (
	.clk(clk),
	.clk_en(clk_en),
	.wr_en(mem_we_q),
	.erase(mem_er_q),
	.wr_addr(mem_wa_q),
	.wr_data(mem_wd_q),
	.rd_addr(rd_addr),
	.rd_data(rd_data)
);
endmodule

/* File: test/fpp_assertions.sv */
// Pin-level checker for the flash programming port.
// Assumes it is bound into fpp_top; one clock domain, async low reset.
`timescale 1ns/100ps
`include "fpp_regs.vh"
module fpp_assertions (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Control pins
	input wire prog_reset,
	input wire program_store_enable_n,
	input wire program_strobe,
	input wire high_voltage_enable,
	input wire mode_select_a,
	input wire mode_select_enable,
	input wire mode_select_b,
	input wire mode_select_c,
	input wire mode_select_d,
	// Outputs watched
	input wire miso_oe,
	input wire data_port_oe,
	input wire busy_output_pin,
	input wire [2:0] lock_bits_q,
	input wire prog_enabled
);
	////////////////////////////////////////////////////////////
	// Select word and the strobes that must start a cycle
	wire [4:0] sel = {mode_select_a, mode_select_enable, mode_select_b,
		mode_select_c, mode_select_d};
	wire go = !program_store_enable_n && prog_reset && high_voltage_enable &&
		!lock_bits_q[0] && (sel == `FPP_SEL_WRITE || sel == `FPP_SEL_ERASE);
	reg [12:0] low_q;
	// Busy length counter; wide enough for a serial cycle too
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) low_q <= 13'h0000;
		else if (busy_output_pin) low_q <= 13'h0000;
		else low_q <= low_q + 13'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_busy_prompt: assert property (
		$rose(program_strobe) && busy_output_pin && go |-> ##[1:10] !busy_output_pin)
		else $error("busy not low soon after strobe");
	a_busy_span: assert property (
		$rose(busy_output_pin) && !program_store_enable_n |-> low_q >= 13'd400 && low_q <= 13'd500)
		else $error("parallel busy span out of range");
	a_busy_hold: assert property (
		$fell(busy_output_pin) |=> !busy_output_pin [*8]) else $error("busy released early");
	a_hv_refuse: assert property (
		$rose(program_strobe) && busy_output_pin && !high_voltage_enable
		&& $stable(high_voltage_enable) |=> busy_output_pin [*8]) else $error("strobe taken without hv");
	a_lock_time: assert property (
		$changed(lock_bits_q) |-> !busy_output_pin || !$past(busy_output_pin))
		else $error("lock bits changed outside a cycle");
	a_miso_drive: assert property (
		miso_oe |-> prog_enabled) else $error("miso driven before enable");
	a_session_end: assert property (
		!prog_reset [*4] |=> !prog_enabled) else $error("session kept after reset low");
	a_data_float: assert property (
		program_store_enable_n [*4] |=> !data_port_oe) else $error("data port driven outside parallel mode");
endmodule
bind fpp_top fpp_assertions u_chk (.clk, .arst_n, .prog_reset, .program_store_enable_n,
	.program_strobe, .high_voltage_enable, .mode_select_a, .mode_select_enable,
	.mode_select_b, .mode_select_c, .mode_select_d, .miso_oe, .data_port_oe,
	.busy_output_pin, .lock_bits_q, .prog_enabled);

/* File: test/fpp_isp_host.sv */
// Serial programmer model: shifts whole instructions, collects the reply.
// Assumes the bench calls xfer; shift clock is 8 core clocks, 800 ns.
`timescale 1ns/100ps
module fpp_isp_host (
	// Clock
	input wire clk,
	// Serial pins
	output reg sck,
	output wire mosi,
	input wire miso
);
	reg active;
	reg tx_bit;
	reg idle_bit;
	initial begin
		sck = 1'b0;
		tx_bit = 1'b0;
		idle_bit = 1'b0;
		active = 1'b0;
	end
	// Data line wiggles between frames so no stale bit is trusted
	always @(posedge clk) if (!active) idle_bit <= ~idle_bit;
	assign mosi = active ? tx_bit : idle_bit;
	// shift clock pace fixed at 8 core clocks per bit
	task automatic xfer(input [31:0] w, output [7:0] r);
		integer i;
		@(posedge clk);
		active <= 1'b1;
		for (i = 31; i >= 0; i = i - 1) begin
			@(posedge clk);
			sck <= 1'b0;
			tx_bit <= w[i];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			r = {r[6:0], miso};
			repeat (3) @(posedge clk);
		end
		@(posedge clk);
		sck <= 1'b0;
		active <= 1'b0;
	endtask
endmodule

/* File: test/fpp_top_tb_top.sv */
// Bench for the flash programming port: parallel and serial sessions.
// Assumes the serial model in fpp_isp_host and the bound checker.
`timescale 1ns/100ps
`include "fpp_regs.vh"
module fpp_top_tb_top;
	reg clk, arst_n, prog_reset, store_n, strobe, hv;
	reg [4:0] sel;
	reg [11:0] addr, a;
	reg [7:0] din, d, r;
	reg [31:0] rnd;
	wire sck, mosi, miso, miso_oe, dout_oe, busy, enabled;
	wire [7:0] dout;
	wire [2:0] locks;
	integer fails, check_count, i, j;
	fpp_top uut (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .prog_reset(prog_reset),
		.sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.program_store_enable_n(store_n), .program_strobe(strobe), .high_voltage_enable(hv),
		.mode_select_a(sel[4]), .mode_select_enable(sel[3]), .mode_select_b(sel[2]),
		.mode_select_c(sel[1]), .mode_select_d(sel[0]), .high_address_port(addr[11:8]),
		.low_address_port(addr[7:0]), .data_port_in(din), .data_port_out(dout),
		.data_port_oe(dout_oe), .busy_output_pin(busy), .lock_bits_q(locks),
		.prog_enabled(enabled));
	fpp_isp_host host (.clk(clk), .sck(sck), .mosi(mosi), .miso(miso));
	////////////////////////////////////////////////////////////
	// Core clock, 100 ns
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cyc(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks=%0d mismatches=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Parallel access: selects, address, data, optional 300 ns strobe
	task par(input [4:0] s, input [11:0] ad, input [7:0] v, input pulse);
		@(posedge clk);
		sel <= s;
		addr <= ad;
		din <= v;
		cyc(4);
		if (pulse) begin
			strobe <= 1'b1;
			cyc(3);
			strobe <= 1'b0;
		end
		cyc(8);
	endtask
	task prog(input [4:0] s, input [11:0] ad, input [7:0] v);
		par(s, ad, v, 1'b1);
		chk({7'h00, busy}, 8'h00);
	endtask
	// Wait for ready, bounded
	task ready;
		for (j = 0; j < 700 && busy !== 1'b1; j = j + 1) cyc(1);
		chk({7'h00, busy}, 8'h01);
	endtask
	// Watchdog
	initial begin
		cyc(60000);
		fails = fails + 1;
		stop_test;
	end
	initial begin
		fails = 0;
		check_count = 0;
		rnd = 32'hf8c2_1224;
		{arst_n, strobe, store_n, din, addr} = 0;
		// reset pin high from power-up, clock running before serial use
		{prog_reset, hv} = 2'b11;
		sel = `FPP_SEL_READ;
		cyc(12);
		arst_n <= 1'b1;
		cyc(4);
		prog(`FPP_SEL_ERASE, 12'h000, 8'h00);
		ready;
		par(`FPP_SEL_READ, 12'h5a3, 8'h00, 1'b0);
		chk(dout, `FPP_ERASED);
		for (i = 0; i < 4; i = i + 1) begin
			rnd = lfsr(rnd);
			d = rnd[7:0];
			a = (i == 0) ? 12'hfff : rnd[19:8];
			prog(`FPP_SEL_WRITE, a, d);
			par(`FPP_SEL_READ, a, 8'h00, 1'b0);
			chk({7'h00, dout[7]}, {7'h00, ~d[7]});
			ready;
			par(`FPP_SEL_READ, a, 8'h00, 1'b0);
			chk(dout, d);
		end
		hv <= 1'b0;
		par(`FPP_SEL_WRITE, a, ~d, 1'b1);
		chk({7'h00, busy}, 8'h01);
		hv <= 1'b1;
		prog(`FPP_SEL_WRITE, 12'h001, 8'h3c);
		par(`FPP_SEL_WRITE, 12'h001, 8'hc3, 1'b1);
		ready;
		par(`FPP_SEL_READ, 12'h001, 8'h00, 1'b0);
		chk(dout, 8'h3c);
		$display("parallel code tests done");
		store_n <= 1'b1;
		host.xfer({`FPP_OP_READ, 4'h0, a, 8'h00}, r);
		chk(r, 8'h00);
		host.xfer({`FPP_OP_ENABLE, `FPP_OP_ENABLE2, 16'h0000}, r);
		chk(r, `FPP_ENABLE_ECHO);
		rnd = lfsr(rnd);
		a = rnd[11:0];
		d = rnd[19:12];
		host.xfer({`FPP_OP_WRITE, 4'h0, a, d}, r);
		host.xfer({`FPP_OP_READ, 4'h0, a, 8'h00}, r);
		chk({7'h00, r[7]}, {7'h00, ~d[7]});
		cyc(5000);
		host.xfer({`FPP_OP_READ, 4'h0, a, 8'h00}, r);
		chk(r, d);
		chk({7'h00, enabled}, 8'h01);
		// reset pin dropped with the shift clock already idle low
		prog_reset <= 1'b0;
		cyc(8);
		chk({7'h00, enabled}, 8'h00);
		$display("serial tests done");
		prog_reset <= 1'b1;
		store_n <= 1'b0;
		cyc(4);
		for (i = 0; i < 3; i = i + 1) begin
			par(`FPP_SEL_IDENT, i << 8, 8'h00, 1'b0);
			chk(dout, i == 0 ? `FPP_ID0 : i == 1 ? `FPP_ID1 : `FPP_ID2);
		end
		for (i = 0; i < 3; i = i + 1) begin
			prog(i == 0 ? `FPP_SEL_LOCK1 : i == 1 ? `FPP_SEL_LOCK2 : `FPP_SEL_LOCK3, 0, 0);
			ready;
		end
		chk({5'h00, locks}, 8'h07);
		par(`FPP_SEL_LOCKRD, 12'h000, 8'h00, 1'b0);
		chk({5'h00, dout[4:2]}, 8'h07);
		$display("identity and lock tests done");
		stop_test;
	end
endmodule
